// [hw/afda_pkg.sv]
// package for the alu flag and data addressing block
// assumes one clock domain; registers reached over apb with 32-bit data
package afda_pkg;
   // register byte offsets
   localparam logic [11:0] OFS_STATUS = 12'h000;
   localparam logic [11:0] OFS_BANK = 12'h004;
   localparam logic [11:0] OFS_PTR0 = 12'h008;
   localparam logic [11:0] OFS_PTR1 = 12'h00c;
   localparam logic [11:0] OFS_PTR2 = 12'h010;
   localparam logic [11:0] OFS_CFG = 12'h014;
   localparam logic [11:0] OFS_RESULT = 12'h018;
   // status field positions
   localparam int B_CARRY = 0;
   localparam int B_NIB = 1;
   localparam int B_ZERO = 2;
   localparam int B_WRAP = 3;
   localparam int B_NEG = 4;
   localparam logic [7:0] STATUS_MASK = 8'h1f;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] STATUS_ADDR_LO = 8'hd8;
   localparam logic [11:0] STATUS_ADDR = 12'hfd8;
   localparam logic [7:0] INDEX_LIMIT = 8'h5f;
   localparam logic [7:0] ACCESS_SPLIT = 8'h80;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
   localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
   localparam logic [11:0] ONE12 = 12'h001;

   typedef enum logic [3:0] {
      AFDA_OP_ADD = 4'h0,    // add_reg_op / add_literal_op
      AFDA_OP_SUB = 4'h1,    // reg_minus_op / literal_minus_op
      AFDA_OP_RRC = 4'h2,    // rotate_right_op through carry
      AFDA_OP_RLC = 4'h3,    // rotate_left_op through carry
      AFDA_OP_AND = 4'h4,
      AFDA_OP_IOR = 4'h5,
      AFDA_OP_XOR = 4'h6,
      AFDA_OP_CLR = 4'h7,    // register_zeroing_op
      AFDA_OP_MOV = 4'h8,    // moves without flags
      AFDA_OP_SWAP = 4'h9,   // nibble_exchange_op
      AFDA_OP_BSET = 4'ha,
      AFDA_OP_BCLR = 4'hb
   } afda_op_t;

   typedef enum logic [2:0] {
      AFDA_AM_DIRECT = 3'h0,  // 8-bit file address with access bit
      AFDA_AM_FULL = 3'h1,    // complete 12-bit address
      AFDA_AM_IND = 3'h2,     // pointer_operand, no change
      AFDA_AM_POSTINC = 3'h3, // auto_bump_operand
      AFDA_AM_POSTDEC = 3'h4,
      AFDA_AM_PREINC = 3'h5,
      AFDA_AM_PLUSW = 3'h6,
      AFDA_AM_NONE = 3'h7     // inherent or literal
   } afda_amode_t;

   typedef struct packed {
      afda_op_t op;
      afda_amode_t amode;
      logic access_sel;
      logic dest_sel;
      logic implicit_reg;
      logic [1:0] ptr_sel;
      logic [7:0] file_addr;
      logic [11:0] full_addr;
      logic [19:0] jump_target;
      logic [7:0] operand_b;
      logic [2:0] bit_num;
   } afda_req_t;

   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] data;
      logic to_reg;
      logic to_acc;
      logic [19:0] jump_target;
   } afda_rsp_t;
endpackage

// [hw/afda_core.sv]
// alu status flags and data-memory operand address generation
// assumes decoder gives one instruction per req_valid pulse, operand a already read
// from data memory; apb master follows the usual setup/access sequence
//
// How it works
// RULE1 - flag-affecting op aimed at status register drops result, only updates flags
// RULE2 - software should alter status only with bit, swap, full move, store ops
// RULE3 - subtraction adds two's complement; carry and nibble carry mean not-borrow
// RULE4 - status bits 7 to 5 read zero and ignore writes
// RULE5 - negative flag bit 4 copies result bit 7
// RULE6 - wrap flag bit 3 set on signed overflow changing sign bit
// RULE7 - zero flag bit 2 set when result is zero
// RULE8 - add/sub nibble carry bit 1 is carry out of bit 3
// RULE9 - rotate through carry loads nibble carry with source bit 4 or 3
// RULE10 - add/sub carry bit 0 is carry out of bit 7
// RULE11 - rotate through carry loads carry with the bit shifted out
// RULE12 - call and jump carry a 20-bit program address literal
// RULE13 - access bit one joins bank pointer and file address into 12 bits
// RULE14 - access bit zero maps file address into access bank, bank pointer ignored
// RULE15 - full-address moves ignore bank pointer
// RULE16 - destination bit one writes source register, zero writes accumulator
// RULE17 - indirect takes address from pointer pair, pairs are also registers
// RULE18 - virtual operands post-increment, post-decrement, pre-increment or offset pointer
// RULE19 - indexed literal offset only with extended ops configuration set
// RULE20 - pointer bumps carry across the pair and leave flags alone
// RULE21 - extended, access bank, address up to 5fh: offset from third pointer
// RULE22 - ops that do not affect flags keep every flag
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ns
module afda_core (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // instruction from decoder
   input wire logic req_valid,
   input wire afda_pkg::afda_req_t req,
   input wire logic [7:0] operand_a,
   input wire logic [7:0] accumulator,
   // resolved operation to data memory
   output logic rsp_valid,
   output afda_pkg::afda_rsp_t rsp,
   output logic [7:0] status_out
);
   logic [7:0] status;
   logic [3:0] bank_pointer;
   logic [11:0] pointer_pair [3];
   logic extended_ops_config;
   logic [7:0] last_result;

   // 12-bit pointer step, roll-over of the low byte reaches the high byte
   function automatic logic [11:0] bump(input logic [11:0] p, input logic up);
      bump = up ? p + afda_pkg::ONE12 : p - afda_pkg::ONE12; // [RULE20]
   endfunction

   function automatic logic [11:0] word_to_ptr(input logic [31:0] w);
      word_to_ptr = w[11:0];
   endfunction

   // registers sit in the low bits of the bus word, the rest reads zero
   function automatic logic [31:0] reg_word(input logic [11:0] v);
      reg_word = {20'h00000, v};
   endfunction

   function automatic logic [7:0] bit_mask(input logic [2:0] n);
      bit_mask = 8'h01 << n;
   endfunction

   // access bank: low half of bank 0 or high half of the last bank
   function automatic logic [11:0] access_bank(input logic [7:0] f);
      if (f < afda_pkg::ACCESS_SPLIT) begin
         access_bank = {afda_pkg::ACCESS_LO_BANK, f};
      end else begin
         access_bank = {afda_pkg::ACCESS_HI_BANK, f};
      end
   endfunction

   // alu
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] b_eff;
   logic carry_in_add;
   logic [7:0] alu_res;
   logic [4:0] next_flags;
   logic flags_hit;
   afda_pkg::afda_op_t op;
   assign op = req.op;

   always_comb begin
      // subtract as a plus ~b plus one, so carry reads as not-borrow [RULE3]
      b_eff = (op == afda_pkg::AFDA_OP_SUB) ? ~req.operand_b : req.operand_b;
      carry_in_add = (op == afda_pkg::AFDA_OP_SUB);
      sum = {1'b0, operand_a} + {1'b0, b_eff} + {8'h00, carry_in_add};
      nib = {1'b0, operand_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, carry_in_add};
      next_flags = status[4:0];
      flags_hit = 1'b0;
      alu_res = operand_a;
      case (op)
         afda_pkg::AFDA_OP_ADD, afda_pkg::AFDA_OP_SUB: begin
            alu_res = sum[7:0];
            flags_hit = 1'b1;
            next_flags[afda_pkg::B_CARRY] = sum[8]; // [RULE10]
            next_flags[afda_pkg::B_NIB] = nib[4]; // [RULE8]
            next_flags[afda_pkg::B_WRAP] = (operand_a[7] == b_eff[7]) && (sum[7] != operand_a[7]); // [RULE6]
         end
         afda_pkg::AFDA_OP_RRC: begin
            alu_res = {status[afda_pkg::B_CARRY], operand_a[7:1]};
            flags_hit = 1'b1;
            next_flags[afda_pkg::B_CARRY] = operand_a[0]; // [RULE11]
            next_flags[afda_pkg::B_NIB] = operand_a[4]; // [RULE9]
         end
         afda_pkg::AFDA_OP_RLC: begin
            alu_res = {operand_a[6:0], status[afda_pkg::B_CARRY]};
            flags_hit = 1'b1;
            next_flags[afda_pkg::B_CARRY] = operand_a[7]; // [RULE11]
            next_flags[afda_pkg::B_NIB] = operand_a[3]; // [RULE9]
         end
         afda_pkg::AFDA_OP_AND: begin
            alu_res = operand_a & req.operand_b;
            flags_hit = 1'b1;
         end
         afda_pkg::AFDA_OP_IOR: begin
            alu_res = operand_a | req.operand_b;
            flags_hit = 1'b1;
         end
         afda_pkg::AFDA_OP_XOR: begin
            alu_res = operand_a ^ req.operand_b;
            flags_hit = 1'b1;
         end
         afda_pkg::AFDA_OP_CLR: begin
            // only zero changes here, so clearing status gives 000u u1uu
            alu_res = 8'h00;
            next_flags[afda_pkg::B_ZERO] = 1'b1; // [RULE7]
         end
         afda_pkg::AFDA_OP_SWAP: begin
            alu_res = {operand_a[3:0], operand_a[7:4]}; // [RULE22]
         end
         afda_pkg::AFDA_OP_BSET: begin
            alu_res = operand_a | bit_mask(req.bit_num); // [RULE22]
         end
         afda_pkg::AFDA_OP_BCLR: begin
            alu_res = operand_a & ~bit_mask(req.bit_num); // [RULE22]
         end
         afda_pkg::AFDA_OP_MOV: begin
            alu_res = operand_a; // [RULE22]
         end
         default: begin
            alu_res = operand_a;
         end
      endcase
      if (flags_hit) begin
         next_flags[afda_pkg::B_NEG] = alu_res[7]; // [RULE5]
         next_flags[afda_pkg::B_ZERO] = (alu_res == 8'h00); // [RULE7]
      end
   end

   // address generation
   logic [11:0] ea;
   logic [11:0] ptr_cur;
   logic [11:0] ptr_new;
   logic ptr_upd;
   logic is_flag_op;
   logic dst_reg;
   logic ptr_ok;
   always_comb begin
      // select three has no pair behind it: it reads zero and moves nothing
      ptr_ok = (req.ptr_sel != 2'h3);
      ptr_cur = 12'h000;
      if (ptr_ok) begin
         ptr_cur = pointer_pair[req.ptr_sel];
      end
      ptr_new = ptr_cur;
      ptr_upd = 1'b0;
      ea = 12'h000;
      case (req.amode)
         afda_pkg::AFDA_AM_DIRECT: begin
            if (req.access_sel) begin
               ea = {bank_pointer, req.file_addr}; // [RULE13]
            end else if (extended_ops_config && req.file_addr <= afda_pkg::INDEX_LIMIT) begin
               ea = pointer_pair[2] + {4'h0, req.file_addr}; // [RULE19] [RULE21]
            end else begin
               ea = access_bank(req.file_addr); // [RULE14]
            end
         end
         afda_pkg::AFDA_AM_FULL: begin
            ea = req.full_addr; // [RULE15]
         end
         afda_pkg::AFDA_AM_IND: begin
            ea = ptr_cur; // [RULE17]
         end
         afda_pkg::AFDA_AM_POSTINC: begin
            ea = ptr_cur;
            ptr_new = bump(ptr_cur, 1'b1); // [RULE18]
            ptr_upd = 1'b1;
         end
         afda_pkg::AFDA_AM_POSTDEC: begin
            ea = ptr_cur;
            ptr_new = bump(ptr_cur, 1'b0); // [RULE18]
            ptr_upd = 1'b1;
         end
         afda_pkg::AFDA_AM_PREINC: begin
            ptr_new = bump(ptr_cur, 1'b1); // [RULE18]
            ea = ptr_new;
            ptr_upd = 1'b1;
         end
         afda_pkg::AFDA_AM_PLUSW: begin
            ea = ptr_cur + {{4{accumulator[7]}}, accumulator}; // [RULE18]
         end
         default: begin
            ea = 12'h000;
         end
      endcase
      ptr_upd = ptr_upd && ptr_ok;
      is_flag_op = flags_hit || (op == afda_pkg::AFDA_OP_CLR);
      dst_reg = req.implicit_reg || req.dest_sel; // [RULE16]
   end

   logic to_status;
   assign to_status = (req.amode != afda_pkg::AFDA_AM_NONE) && dst_reg && (ea == afda_pkg::STATUS_ADDR);

   // apb decode
   logic apb_wr;
   logic apb_rd;
   logic apb_hit;
   logic apb_setup;
   assign apb_setup = psel && !penable;
   assign apb_wr = psel && penable && pwrite;
   assign apb_rd = apb_setup && !pwrite;
   always_comb begin
      case (paddr)
         afda_pkg::OFS_STATUS, afda_pkg::OFS_BANK, afda_pkg::OFS_PTR0, afda_pkg::OFS_PTR1,
         afda_pkg::OFS_PTR2, afda_pkg::OFS_CFG, afda_pkg::OFS_RESULT: begin
            apb_hit = 1'b1;
         end
         default: begin
            apb_hit = 1'b0;
         end
      endcase
   end

   // status; instruction beats a same-cycle bus write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= afda_pkg::STATUS_RESET;
      end else if (req_valid && to_status && !is_flag_op) begin
         status <= alu_res & afda_pkg::STATUS_MASK; // [RULE4] [RULE22]
      end else if (req_valid) begin
         status <= {3'b000, next_flags}; // [RULE1] [RULE4]
      end else if (apb_wr && paddr == afda_pkg::OFS_STATUS) begin
         status <= pwdata[7:0] & afda_pkg::STATUS_MASK; // [RULE4]
      end
   end

   // pointer pairs; bump wins over a bus write in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pointer_pair[0] <= 12'h000;
         pointer_pair[1] <= 12'h000;
         pointer_pair[2] <= 12'h000;
      end else if (req_valid && ptr_upd) begin
         pointer_pair[req.ptr_sel] <= ptr_new; // [RULE20]
      end else if (apb_wr) begin
         if (paddr == afda_pkg::OFS_PTR0) begin
            pointer_pair[0] <= word_to_ptr(pwdata); // [RULE17]
         end
         if (paddr == afda_pkg::OFS_PTR1) begin
            pointer_pair[1] <= word_to_ptr(pwdata); // [RULE17]
         end
         if (paddr == afda_pkg::OFS_PTR2) begin
            pointer_pair[2] <= word_to_ptr(pwdata); // [RULE17]
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bank_pointer <= 4'h0;
      end else if (apb_wr && paddr == afda_pkg::OFS_BANK) begin
         bank_pointer <= pwdata[3:0]; // [RULE13]
      end
   end

   // extended ops switch, off after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         extended_ops_config <= 1'b0;
      end else if (apb_wr && paddr == afda_pkg::OFS_CFG) begin
         extended_ops_config <= pwdata[0]; // [RULE19]
      end
   end

   // resolved operation
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsp_valid <= 1'b0;
         rsp <= '0;
      end else begin
         rsp_valid <= req_valid;
         if (req_valid) begin
            rsp.addr <= ea;
            rsp.data <= alu_res;
            rsp.to_reg <= dst_reg && !(to_status && is_flag_op); // [RULE1] [RULE16]
            rsp.to_acc <= !dst_reg; // [RULE16]
            rsp.jump_target <= req.jump_target; // [RULE12]
         end
      end
   end

   // last alu result, kept for software to read back
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_result <= 8'h00;
      end else if (req_valid) begin
         last_result <= alu_res;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_out <= afda_pkg::STATUS_RESET;
      end else begin
         status_out <= status;
      end
   end

   // apb answer: one access cycle after every setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= apb_setup;
         pslverr <= apb_setup && !apb_hit;
      end
   end

   // read data latched in setup, so it already stands in the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (apb_rd) begin
         case (paddr)
            afda_pkg::OFS_STATUS: begin
               prdata <= reg_word({4'h0, status}); // [RULE4]
            end
            afda_pkg::OFS_BANK: begin
               prdata <= reg_word({8'h00, bank_pointer});
            end
            afda_pkg::OFS_PTR0: begin
               prdata <= reg_word(pointer_pair[0]); // [RULE17]
            end
            afda_pkg::OFS_PTR1: begin
               prdata <= reg_word(pointer_pair[1]); // [RULE17]
            end
            afda_pkg::OFS_PTR2: begin
               prdata <= reg_word(pointer_pair[2]); // [RULE17]
            end
            afda_pkg::OFS_CFG: begin
               prdata <= reg_word({11'h000, extended_ops_config});
            end
            afda_pkg::OFS_RESULT: begin
               prdata <= reg_word({4'h0, last_result});
            end
            default: begin
               prdata <= 32'h0000_0000;
            end
         endcase
      end
   end
endmodule

// [bench/afda_dmem.sv]
// data memory partner: keeps what the core sends to a register
// assumes rsp fields are settled while rsp_valid is high
`timescale 1ns/1ns
module afda_dmem (
   // clock
   input wire logic pclk,
   // result from the core
   input wire logic rsp_valid,
   input wire afda_pkg::afda_rsp_t rsp,
   // read port for the decoder side
   input wire logic [11:0] rd_addr,
   output logic [7:0] rd_data
);
   logic [7:0] mem [4096];
   // accumulator results never touch memory
   always @(posedge pclk) begin
      if (rsp_valid && rsp.to_reg) begin
         mem[rsp.addr] <= rsp.data;
      end
   end
   assign rd_data = mem[rd_addr];
endmodule

// [bench/afda_core_sva.sv]
// checker for afda_core: flag results and resolved addresses
// assumes it is bound to afda_core, one clock, reset presetn
`timescale 1ns/1ns
module afda_core_sva (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // watched ports
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic req_valid,
   input wire afda_pkg::afda_req_t req,
   input wire logic [7:0] operand_a,
   input wire afda_pkg::afda_rsp_t rsp,
   input wire logic [7:0] status_out
);
   logic [8:0] sum;
   logic [8:0] dif;
   logic [4:0] nib;
   logic add_go;
   logic sub_go;
   assign sum = {1'b0, operand_a} + {1'b0, req.operand_b};
   assign dif = {1'b0, operand_a} + {1'b0, ~req.operand_b} + 9'h001;
   assign nib = {1'b0, operand_a[3:0]} + {1'b0, req.operand_b[3:0]};
   assign add_go = req_valid && req.op == afda_pkg::AFDA_OP_ADD;
   assign sub_go = req_valid && req.op == afda_pkg::AFDA_OP_SUB;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // flags show on status_out two edges after the op; a bus write could mask it
   sequence s_quiet_op;
      req_valid && req.op >= afda_pkg::AFDA_OP_MOV && !(psel && penable && pwrite)
         ##1 rsp.addr != afda_pkg::STATUS_ADDR;
   endsequence
   a_upper_zero: assert property (status_out[7:5] == 3'h0)
      else $error("status upper bits set");
   a_add_carry: assert property (add_go |-> ##2 status_out[0] == $past(sum[8], 2))
      else $error("add carry wrong");
   a_add_nibble: assert property (add_go |-> ##2 status_out[1] == $past(nib[4], 2))
      else $error("add nibble carry wrong");
   a_sub_borrow: assert property (sub_go |-> ##2 status_out[0] == $past(dif[8], 2))
      else $error("sub borrow wrong");
   a_zero_neg: assert property (add_go |-> ##2 status_out[2] == ($past(sum[7:0], 2) == 8'h00)
      && status_out[4] == $past(sum[7], 2)) else $error("zero or negative flag wrong");
   a_wrap_flag: assert property (add_go && operand_a[7] == req.operand_b[7] && sum[7] != operand_a[7]
      |-> ##2 status_out[3]) else $error("wrap flag missing");
   a_keep_flags: assert property (s_quiet_op |=> $stable(status_out))
      else $error("flags moved on a quiet op");
   a_full_addr: assert property (req_valid && req.amode == afda_pkg::AFDA_AM_FULL
      |=> rsp.addr == $past(req.full_addr)) else $error("full address altered");
   a_jump_lit: assert property (req_valid |=> rsp.jump_target == $past(req.jump_target))
      else $error("jump target lost");
endmodule
bind afda_core afda_core_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .req_valid(req_valid), .req(req), .operand_a(operand_a), .rsp(rsp), .status_out(status_out));

// [bench/alu_flags_and_data_addressing_tb.sv]
// testbench for afda_core: apb registers, flags of every op, operand addresses
// assumes package, core, checker and data memory model compiled before it
`timescale 1ns/1ns
module alu_flags_and_data_addressing_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic req_valid = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [7:0] operand_a = 8'h00;
   logic [7:0] accumulator = 8'h00;
   afda_pkg::afda_req_t req = '0;
   logic pready, pslverr, rsp_valid;
   logic [31:0] prdata;
   logic [7:0] status_out, rd_data, st;
   afda_pkg::afda_rsp_t rsp;
   logic [21:0] exp_rsp[$];
   logic [32:0] exp_rd[$];
   int bad_count = 0;
   int comparisons = 0;
   int cycles = 0;
   afda_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req(req),
      .operand_a(operand_a), .accumulator(accumulator), .rsp_valid(rsp_valid), .rsp(rsp), .status_out(status_out));
   afda_dmem u_mem (.pclk(pclk), .rsp_valid(rsp_valid), .rsp(rsp), .rd_addr(12'h1a5), .rd_data(rd_data));
   initial begin
      forever #4 pclk = ~pclk;
   end
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // taken at the rising edge where pready or rsp_valid is seen high
   always @(posedge pclk) begin
      if (presetn && rsp_valid) begin
         check({11'h0, rsp.addr, rsp.data, rsp.to_reg, rsp.to_acc}, {11'h0, exp_rsp.pop_front()});
      end
      if (presetn && psel && penable && pready && !pwrite) begin
         check({pslverr, prdata}, exp_rd.pop_front());
      end
   end
   always @(posedge pclk) begin
      cycles++;
      if (cycles > 20000) begin
         bad_count++;
         give_verdict();
      end
   end
   // also ends any instruction left raised by op
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
      @(posedge pclk);
      req_valid <= 1'b0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      if (!wr) begin
         exp_rd.push_back(e);
      end
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (!pready);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // raises one instruction; back-to-back calls give one per cycle
   task automatic op(input afda_pkg::afda_req_t r, input logic [7:0] a, input logic [21:0] e);
      @(posedge pclk);
      req_valid <= 1'b1;
      req <= r;
      operand_a <= a;
      exp_rsp.push_back(e);
   endtask
   function automatic afda_pkg::afda_req_t mk(input logic [3:0] o, input logic [2:0] m, input logic s,
      input logic [7:0] f, input logic [11:0] fa, input logic [7:0] b);
      mk = '0;
      mk.op = afda_pkg::afda_op_t'(o);
      mk.amode = afda_pkg::afda_amode_t'(m);
      mk.access_sel = s;
      mk.dest_sel = 1'b1;
      mk.file_addr = f;
      mk.full_addr = fa;
      mk.operand_b = b;
      mk.bit_num = b[2:0];
      mk.jump_target = 20'($urandom);
   endfunction
   // returns result and new status
   function automatic logic [15:0] model(input logic [3:0] o, input logic [7:0] a, input logic [7:0] b,
      input logic [7:0] s);
      logic [7:0] c;
      logic [8:0] w;
      logic [4:0] h;
      logic [7:0] r;
      logic [7:0] f;
      c = (o == 4'h1) ? ~b : b;
      w = {1'b0, a} + {1'b0, c} + {8'h00, o == 4'h1};
      h = {1'b0, a[3:0]} + {1'b0, c[3:0]} + {4'h0, o == 4'h1};
      f = s;
      case (o)
         4'h0, 4'h1: r = w[7:0];
         4'h2: r = {s[0], a[7:1]};
         4'h3: r = {a[6:0], s[0]};
         4'h4: r = a & b;
         4'h5: r = a | b;
         4'h6: r = a ^ b;
         4'h7: r = 8'h00;
         4'h9: r = {a[3:0], a[7:4]};
         4'ha: r = a | (8'h01 << b[2:0]);
         4'hb: r = a & ~(8'h01 << b[2:0]);
         default: r = a;
      endcase
      if (o < 4'h2) f[3:0] = {a[7] == c[7] && r[7] != a[7], f[2], h[4], w[8]};
      if (o == 4'h2) f[1:0] = {a[4], a[0]};
      if (o == 4'h3) f[1:0] = {a[3], a[7]};
      if (o < 4'h7) f[4] = r[7];
      if (o < 4'h8) f[2] = r == 8'h00;
      return {r, f};
   endfunction
   initial begin
      logic [15:0] m;
      logic [7:0] a;
      logic [7:0] b;
      afda_pkg::afda_req_t r;
      void'($urandom(32'h0160));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, afda_pkg::OFS_STATUS, 32'h0, 33'h0);
      apb(1'b0, 12'h01c, 32'h0, 33'h100000000);
      apb(1'b1, afda_pkg::OFS_STATUS, 32'hffffffff, 33'h0);
      apb(1'b0, afda_pkg::OFS_STATUS, 32'h0, 33'h1f);
      st = 8'h1f;
      repeat (3) begin
         for (int i = 0; i < 12; i++) begin
            a = 8'($urandom);
            b = 8'($urandom);
            m = model(i[3:0], a, b, st);
            op(mk(i[3:0], 3'h1, 1'b0, 8'h00, 12'h100 | 12'(b), b), a, {12'h100 | 12'(b), m[15:8], 2'b10});
            st = m[7:0];
            apb(1'b0, afda_pkg::OFS_STATUS, 32'h0, {25'h0, st});
         end
      end
      // flag op into status keeps only flags; a bit set right after writes it whole
      m = model(4'h0, 8'h7f, 8'h01, st);
      op(mk(4'h0, 3'h1, 1'b0, 8'h00, afda_pkg::STATUS_ADDR, 8'h01), 8'h7f,
         {afda_pkg::STATUS_ADDR, m[15:8], 2'b00});
      apb(1'b0, afda_pkg::OFS_STATUS, 32'h0, {25'h0, m[7:0]});
      op(mk(4'ha, 3'h1, 1'b0, 8'h00, afda_pkg::STATUS_ADDR, 8'h03), 8'h00,
         {afda_pkg::STATUS_ADDR, 8'h08, 2'b10});
      st = 8'h08;
      apb(1'b0, afda_pkg::OFS_STATUS, 32'h0, {25'h0, st});
      apb(1'b1, afda_pkg::OFS_BANK, 32'h5, 33'h0);
      op(mk(4'h8, 3'h0, 1'b1, 8'h3c, 12'h0, 8'h0), a, {12'h53c, a, 2'b10});
      op(mk(4'h8, 3'h0, 1'b0, 8'h3c, 12'h0, 8'h0), a, {12'h03c, a, 2'b10});
      op(mk(4'h8, 3'h0, 1'b0, 8'hc4, 12'h0, 8'h0), a, {12'hfc4, a, 2'b10});
      apb(1'b1, afda_pkg::OFS_CFG, 32'h1, 33'h0);
      apb(1'b1, afda_pkg::OFS_PTR2, 32'h200, 33'h0);
      op(mk(4'h8, 3'h0, 1'b0, 8'h5f, 12'h0, 8'h0), a, {12'h25f, a, 2'b10});
      op(mk(4'h8, 3'h0, 1'b0, 8'h60, 12'h0, 8'h0), a, {12'h060, a, 2'b10});
      op(mk(4'h8, 3'h0, 1'b1, 8'h10, 12'h0, 8'h0), a, {12'h510, a, 2'b10});
      // pointer operands around a low-byte roll-over
      apb(1'b1, afda_pkg::OFS_PTR0, 32'h0ff, 33'h0);
      accumulator <= 8'hfe;
      op(mk(4'h8, 3'h2, 1'b0, 8'h00, 12'h0, 8'h0), a, {12'h0ff, a, 2'b10});
      op(mk(4'h8, 3'h3, 1'b0, 8'h00, 12'h0, 8'h0), a, {12'h0ff, a, 2'b10});
      op(mk(4'h8, 3'h4, 1'b0, 8'h00, 12'h0, 8'h0), a, {12'h100, a, 2'b10});
      op(mk(4'h8, 3'h5, 1'b0, 8'h00, 12'h0, 8'h0), a, {12'h100, a, 2'b10});
      op(mk(4'h8, 3'h6, 1'b0, 8'h00, 12'h0, 8'h0), a, {12'h0fe, a, 2'b10});
      apb(1'b0, afda_pkg::OFS_PTR0, 32'h0, 33'h100);
      apb(1'b0, afda_pkg::OFS_STATUS, 32'h0, {25'h0, st});
      // same add to a register, then to the accumulator
      a = 8'($urandom);
      m = model(4'h0, a, 8'h11, st);
      r = mk(4'h0, 3'h1, 1'b0, 8'h00, 12'h1a5, 8'h11);
      op(r, a, {12'h1a5, m[15:8], 2'b10});
      r.dest_sel = 1'b0;
      op(r, a, {12'h1a5, m[15:8], 2'b01});
      st = m[7:0];
      apb(1'b0, afda_pkg::OFS_STATUS, 32'h0, {25'h0, st});
      repeat (2) @(posedge pclk);
      check({25'h0, rd_data}, {25'h0, m[15:8]});
      check(33'(exp_rsp.size() + exp_rd.size()), 33'h0);
      give_verdict();
   end
endmodule
